// ===== inc/ufsu_pkg.sv
// Purpose: Shared constants for the frame and status unit
// Assumes: Byte offsets are relative to the I/O window base
// Notes: Dword index is the offset with the low two bits dropped
package ufsu_pkg;

    // Byte offsets of the registers in the I/O window
    localparam logic [4:0] HOST_STATUS_OFS = 5'h02;
    localparam logic [4:0] IRQ_ENABLE_OFS = 5'h04;
    localparam logic [4:0] FRAME_COUNTER_OFS = 5'h06;
    localparam logic [4:0] FRAME_LIST_BASE_OFS = 5'h08;
    localparam logic [4:0] FRAME_LENGTH_TRIM_OFS = 5'h0C;

    // Host status flag positions
    localparam int ST_XFER_INT = 0;
    localparam int ST_ERR_INT = 1;
    localparam int ST_RESUME = 2;
    localparam int ST_SYS_ERR = 3;
    localparam int ST_PROC_ERR = 4;
    localparam int ST_HALTED = 5;
    localparam int ST_WIDTH = 6;

    // Interrupt enable positions
    localparam int EN_TIMEOUT_CRC = 0;
    localparam int EN_RESUME = 1;
    localparam int EN_COMPLETE = 2;
    localparam int EN_SHORT = 3;
    localparam int EN_WIDTH = 4;

    // Frame counter and list geometry
    localparam int FRAME_NUM_WIDTH = 11;
    localparam int LIST_INDEX_WIDTH = 10;
    localparam int BASE_LSB = 12;
    localparam int TRIM_WIDTH = 7;
    localparam int XFER_LEN_WIDTH = 11;

    // Reset values
    localparam logic [ST_WIDTH-1:0] HOST_STATUS_RST = 6'h00;
    localparam logic [EN_WIDTH-1:0] IRQ_ENABLE_RST = 4'h0;
    localparam logic [FRAME_NUM_WIDTH-1:0] FRAME_COUNTER_RST = 11'h000;
    localparam logic [31-BASE_LSB:0] FRAME_LIST_BASE_RST = 20'h00000;
    localparam logic [TRIM_WIDTH-1:0] FRAME_LENGTH_TRIM_RST = 7'h40;

    // Frame length in counter clocks is this base plus the trim
    localparam logic [13:0] FRAME_LEN_BASE = 14'h2EA0;

    // Halt sequencing states
    typedef enum logic [2:0] {
        UFSU_HALTED = 3'b001,
        UFSU_RUNNING = 3'b010,
        UFSU_STOPPING = 3'b100
    } ufsu_run_state_t;

endpackage

// ===== design/ufsu_frame_timer.sv
// Purpose: Counts frame length in counter clock ticks
// Assumes: sofTick is a one-cycle strobe at the counter clock rate
// Notes: Trim is sampled only at the start of each frame
`timescale 1ns/1ps
module ufsu_frame_timer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic softReset,
    // Control
    input wire logic run,
    input wire logic sofTick,
    input wire logic [ufsu_pkg::TRIM_WIDTH-1:0] trim,
    // Frame events
    output logic frameStart,
    output logic frameEnd
);

    logic [13:0] tickCount;
    logic [13:0] frameLen;
    logic active;
    logic [13:0] next_tickCount;
    wire lastTick = sofTick && (tickCount == frameLen - 14'h0001);
    wire startNow = run && !active;

    // Counter restarts from zero whenever the schedule is stopped
    always_comb begin
        next_tickCount = tickCount;
        if (!run || startNow || lastTick) begin
            next_tickCount = 14'h0000;
        end else if (sofTick) begin
            next_tickCount = tickCount + 14'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tickCount <= 14'h0000;
            active <= 1'b0;
            frameLen <= 14'h0000;
            frameStart <= 1'b0;
            frameEnd <= 1'b0;
        end else if (softReset) begin
            tickCount <= 14'h0000;
            active <= 1'b0;
            frameLen <= 14'h0000;
            frameStart <= 1'b0;
            frameEnd <= 1'b0;
        end else begin
            tickCount <= next_tickCount;
            active <= run;
            frameStart <= startNow || (run && lastTick);
            frameEnd <= run && active && lastTick;
            // New trim applies from the next frame only
            if (startNow || lastTick) begin
                frameLen <= ufsu_pkg::FRAME_LEN_BASE + {7'h00, trim}; // [R18] [R20]
            end
        end
    end

endmodule

// ===== design/ufsu_core.sv
// Purpose: Status flags, interrupt enables and frame timing of the host
// Assumes: I/O accesses are single-cycle strobes on a dword-wide window
// Notes: Command register lives elsewhere; run and suspend arrive as inputs
`timescale 1ns/1ps

// Behaviour
// R01: Writing one clears a status flag
// R02: Set halted flag once execution stops
// R03: Process error sets flag, stops, interrupts
// R04: System error sets flag, stops, interrupts
// R05: Resume flag only during global suspend
// R06: Transaction error sets error flag, maybe bit0
// R07: Completion with interrupt request sets bit0
// R08: Short packet with detection sets bit0
// R09: Enabled active source raises interrupt
// R10: Process error interrupts regardless of enables
// R11: Disabled sources still set status flags
// R12: Four enables: short, complete, resume, error
// R13: Eleven-bit frame number increments each frame
// R14: Low ten bits index the frame list
// R15: Frame counter writes need stop, full word
// R16: Base keeps bits 31:12, low zero
// R17: Entry address is base plus index, aligned
// R18: Frame length is 11936 plus trim
// R19: Trim resets to 40h, 12000 clocks
// R20: New trim applies from next frame
// R21: Trim resets on controller or global reset
// R22: Software loads base before starting run
// R23: On stop, finish transaction then halt
// R24: Interrupt holds while enabled flags remain
module ufsu_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic hcReset,
    input wire logic globalReset,
    // I/O register window
    input wire logic [4:2] ioAddr,
    input wire logic [3:0] ioByteEn,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [31:0] ioWrData,
    output logic [31:0] ioRdData,
    output logic ioRdValid,
    // Command register state
    input wire logic runControlBit,
    input wire logic globalSuspend,
    output logic clearRunReq,
    // Schedule engine events
    input wire logic transactionBusy,
    input wire logic processErrorEvt,
    input wire logic systemErrorEvt,
    input wire logic resumeSignal,
    input wire logic xferDone,
    input wire logic xferError,
    input wire logic interruptOnComplete,
    input wire logic shortPacketDetect,
    input wire logic [ufsu_pkg::XFER_LEN_WIDTH-1:0] actualLength,
    input wire logic [ufsu_pkg::XFER_LEN_WIDTH-1:0] maxLength,
    // Frame timing
    input wire logic sofTick,
    output logic sofStrobe,
    output logic [ufsu_pkg::FRAME_NUM_WIDTH-1:0] sofFrameNumber,
    output logic [31:0] frameListAddr,
    // System interrupt
    output logic irq
);

    // Returns true when all lanes of a field are enabled
    function automatic logic lanesFull(input logic [3:0] be, input logic [3:0] need);
        lanesFull = ((be & need) == need);
    endfunction

    // Returns true when any lane of a field is enabled
    function automatic logic lanesAny(input logic [3:0] be, input logic [3:0] need);
        lanesAny = ((be & need) != 4'h0);
    endfunction

    logic [ufsu_pkg::ST_WIDTH-1:0] hostStatus;
    logic [ufsu_pkg::EN_WIDTH-1:0] irqEnable;
    logic [ufsu_pkg::FRAME_NUM_WIDTH-1:0] frameCounter;
    logic [31-ufsu_pkg::BASE_LSB:0] frameListBase;
    logic [ufsu_pkg::TRIM_WIDTH-1:0] frameLengthTrim;
    logic completeCause;
    logic shortCause;
    ufsu_pkg::ufsu_run_state_t runState;

    logic [ufsu_pkg::ST_WIDTH-1:0] next_hostStatus;
    logic next_completeCause;
    logic next_shortCause;
    ufsu_pkg::ufsu_run_state_t next_runState;
    logic [31:0] next_ioRdData;

    wire logic softReset = hcReset || globalReset;
    wire logic frameStart;
    wire logic frameEnd;

    // Address decode: each dword holds up to two registers
    wire logic selDw0 = (ioAddr == ufsu_pkg::HOST_STATUS_OFS[4:2]);
    wire logic selDw1 = (ioAddr == ufsu_pkg::IRQ_ENABLE_OFS[4:2]);
    wire logic selDw2 = (ioAddr == ufsu_pkg::FRAME_LIST_BASE_OFS[4:2]);
    wire logic selDw3 = (ioAddr == ufsu_pkg::FRAME_LENGTH_TRIM_OFS[4:2]);

    wire logic statusWr = ioWrite && selDw0 && lanesAny(ioByteEn, 4'hC);
    wire logic enableWr = ioWrite && selDw1 && lanesAny(ioByteEn, 4'h3);
    wire logic counterWr = ioWrite && selDw1 && lanesFull(ioByteEn, 4'hC);
    wire logic baseWr = ioWrite && selDw2;
    wire logic trimWr = ioWrite && selDw3 && ioByteEn[0];

    // Only bits whose byte lane is written can be cleared
    wire logic [ufsu_pkg::ST_WIDTH-1:0] clearMask =
        statusWr && ioByteEn[2] ? ioWrData[16 +: ufsu_pkg::ST_WIDTH] : '0;

    // Event decode
    wire logic shortHit = xferDone && shortPacketDetect && (actualLength < maxLength);
    wire logic iocHit = xferDone && interruptOnComplete;
    wire logic errHit = xferDone && xferError;
    wire logic resumeHit = resumeSignal && globalSuspend;
    wire logic fatalHit = processErrorEvt || systemErrorEvt;

    // Halt sequencing: a running transaction finishes before halting
    wire logic stopDone = !runControlBit && !transactionBusy;
    wire logic enterHalt = (runState != ufsu_pkg::UFSU_HALTED) &&
        (next_runState == ufsu_pkg::UFSU_HALTED);
    wire logic scheduleRun = (runState == ufsu_pkg::UFSU_RUNNING);

    always_comb begin
        next_runState = runState;
        case (runState)
            ufsu_pkg::UFSU_HALTED: begin
                if (runControlBit) begin
                    next_runState = ufsu_pkg::UFSU_RUNNING;
                end
            end
            ufsu_pkg::UFSU_RUNNING: begin
                if (stopDone) begin
                    next_runState = ufsu_pkg::UFSU_HALTED; // [R23]
                end else if (!runControlBit) begin
                    next_runState = ufsu_pkg::UFSU_STOPPING; // [R23]
                end
            end
            ufsu_pkg::UFSU_STOPPING: begin
                if (!transactionBusy) begin
                    next_runState = ufsu_pkg::UFSU_HALTED; // [R23]
                end
            end
            default: begin
                next_runState = ufsu_pkg::UFSU_HALTED;
            end
        endcase
    end

    // Status flags: hardware set wins over a same-cycle clear
    always_comb begin
        next_hostStatus = hostStatus & ~clearMask; // [R01]
        next_completeCause = completeCause;
        next_shortCause = shortCause;
        if (statusWr && ioByteEn[2] && ioWrData[16 + ufsu_pkg::ST_XFER_INT]) begin
            next_completeCause = 1'b0; // [R01]
            next_shortCause = 1'b0;
        end
        if (enterHalt) begin
            next_hostStatus[ufsu_pkg::ST_HALTED] = 1'b1; // [R02]
        end
        if (processErrorEvt) begin
            next_hostStatus[ufsu_pkg::ST_PROC_ERR] = 1'b1; // [R03]
        end
        if (systemErrorEvt) begin
            next_hostStatus[ufsu_pkg::ST_SYS_ERR] = 1'b1; // [R04]
        end
        if (resumeHit) begin
            next_hostStatus[ufsu_pkg::ST_RESUME] = 1'b1; // [R05] [R11]
        end
        if (errHit) begin
            next_hostStatus[ufsu_pkg::ST_ERR_INT] = 1'b1; // [R06] [R11]
        end
        if (iocHit) begin
            next_hostStatus[ufsu_pkg::ST_XFER_INT] = 1'b1; // [R06] [R07] [R11]
            next_completeCause = 1'b1;
        end
        if (shortHit) begin
            next_hostStatus[ufsu_pkg::ST_XFER_INT] = 1'b1; // [R08] [R11]
            next_shortCause = 1'b1;
        end
    end

    // Interrupt: enabled sources, plus fatal errors unconditionally
    wire logic enabledHit =
        (hostStatus[ufsu_pkg::ST_ERR_INT] && irqEnable[ufsu_pkg::EN_TIMEOUT_CRC]) ||
        (hostStatus[ufsu_pkg::ST_RESUME] && irqEnable[ufsu_pkg::EN_RESUME]) ||
        (completeCause && irqEnable[ufsu_pkg::EN_COMPLETE]) ||
        (shortCause && irqEnable[ufsu_pkg::EN_SHORT]); // [R09] [R12]
    wire logic fatalHeld = hostStatus[ufsu_pkg::ST_PROC_ERR] ||
        hostStatus[ufsu_pkg::ST_SYS_ERR]; // [R10] [R03] [R04]

    // Read data mux; unmapped lanes and reserved bits read zero
    always_comb begin
        next_ioRdData = 32'h00000000;
        case (1'b1)
            selDw0: begin
                next_ioRdData[16 +: ufsu_pkg::ST_WIDTH] = hostStatus;
            end
            selDw1: begin
                next_ioRdData[ufsu_pkg::EN_WIDTH-1:0] = irqEnable;
                next_ioRdData[16 +: ufsu_pkg::FRAME_NUM_WIDTH] = frameCounter;
            end
            selDw2: begin
                next_ioRdData[31:ufsu_pkg::BASE_LSB] = frameListBase;
            end
            selDw3: begin
                next_ioRdData[ufsu_pkg::TRIM_WIDTH-1:0] = frameLengthTrim;
            end
            default: begin
                next_ioRdData = 32'h00000000;
            end
        endcase
        next_ioRdData = next_ioRdData & {{8{ioByteEn[3]}}, {8{ioByteEn[2]}},
            {8{ioByteEn[1]}}, {8{ioByteEn[0]}}};
    end

    ufsu_frame_timer frameTimer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .softReset(softReset),
        .run(scheduleRun),
        .sofTick(sofTick),
        .trim(frameLengthTrim), // [R18] [R20]
        .frameStart(frameStart),
        .frameEnd(frameEnd)
    );

    // Run state; a soft reset drops straight to halted
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            runState <= ufsu_pkg::UFSU_HALTED;
        end else if (softReset) begin
            runState <= ufsu_pkg::UFSU_HALTED;
        end else begin
            runState <= next_runState;
        end
    end

    // Status flags and the two hidden causes behind bit 0
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hostStatus <= ufsu_pkg::HOST_STATUS_RST;
            completeCause <= 1'b0;
            shortCause <= 1'b0;
        end else if (softReset) begin
            hostStatus <= ufsu_pkg::HOST_STATUS_RST;
            completeCause <= 1'b0;
            shortCause <= 1'b0;
        end else begin
            hostStatus <= next_hostStatus;
            completeCause <= next_completeCause;
            shortCause <= next_shortCause;
        end
    end

    // Interrupt enables
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irqEnable <= ufsu_pkg::IRQ_ENABLE_RST;
        end else if (softReset) begin
            irqEnable <= ufsu_pkg::IRQ_ENABLE_RST;
        end else if (enableWr && ioByteEn[0]) begin
            irqEnable <= ioWrData[ufsu_pkg::EN_WIDTH-1:0]; // [R12]
        end
    end

    // Frame counter: loads only while stopped, counts at frame end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            frameCounter <= ufsu_pkg::FRAME_COUNTER_RST;
        end else if (softReset) begin
            frameCounter <= ufsu_pkg::FRAME_COUNTER_RST;
        end else if (counterWr && !runControlBit) begin
            frameCounter <= ioWrData[16 +: ufsu_pkg::FRAME_NUM_WIDTH]; // [R15]
        end else if (frameEnd) begin
            frameCounter <= frameCounter + 11'h001; // [R13]
        end
    end

    // Frame list base keeps only the aligned upper bits
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            frameListBase <= ufsu_pkg::FRAME_LIST_BASE_RST;
        end else if (baseWr) begin
            if (ioByteEn[3]) begin
                frameListBase[19:12] <= ioWrData[31:24]; // [R16]
            end
            if (ioByteEn[2]) begin
                frameListBase[11:4] <= ioWrData[23:16]; // [R16]
            end
            if (ioByteEn[1]) begin
                frameListBase[3:0] <= ioWrData[15:12]; // [R16]
            end
        end
    end

    // Frame length trim, back to default on any reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            frameLengthTrim <= ufsu_pkg::FRAME_LENGTH_TRIM_RST; // [R19]
        end else if (softReset) begin
            frameLengthTrim <= ufsu_pkg::FRAME_LENGTH_TRIM_RST; // [R21]
        end else if (trimWr) begin
            frameLengthTrim <= ioWrData[ufsu_pkg::TRIM_WIDTH-1:0]; // [R20]
        end
    end

    // Read answer stands one cycle; idle data is zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ioRdData <= 32'h00000000;
            ioRdValid <= 1'b0;
        end else begin
            ioRdData <= ioRead ? next_ioRdData : 32'h00000000;
            ioRdValid <= ioRead;
        end
    end

    // Event and frame outputs
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clearRunReq <= 1'b0;
            sofStrobe <= 1'b0;
            sofFrameNumber <= ufsu_pkg::FRAME_COUNTER_RST;
            frameListAddr <= 32'h00000000;
            irq <= 1'b0;
        end else begin
            clearRunReq <= fatalHit && !softReset; // [R03] [R04]
            sofStrobe <= frameStart && !softReset;
            sofFrameNumber <= frameCounter; // [R13]
            // Entry address: base, ten-bit index, dword aligned
            frameListAddr <= {frameListBase,
                frameCounter[ufsu_pkg::LIST_INDEX_WIDTH-1:0], 2'b00}; // [R14] [R17]
            irq <= !softReset && (enabledHit || fatalHeld); // [R09] [R24]
        end
    end

endmodule

// ===== dv/ufsu_cmd_model.sv
// Purpose: Command register side of the core: run bit and counter strobe
// Assumes: One counter strobe each cycle keeps a frame at 12000 cycles with the reset trim of 40h
// Notes: Run bit drops when the core asks for it after a fatal error
`timescale 1ns/1ps
module ufsu_cmd_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Bench control
    input wire logic setRun,
    input wire logic clrRun,
    // Core side
    input wire logic clearRunReq,
    output logic runControlBit,
    output logic sofTick
);
    assign sofTick = resetn;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            runControlBit <= 1'b0;
        end else if (clearRunReq || clrRun) begin
            runControlBit <= 1'b0;
        end else if (setRun) begin
            runControlBit <= 1'b1;
        end
    end
endmodule

// ===== dv/ufsu_core_props.sv
// Purpose: Port-level timing checks of the frame and status core
// Assumes: Single clock domain, asynchronous active-low reset
// Notes: Status is only visible through reads and the interrupt
`timescale 1ns/1ps
module ufsu_core_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic hcReset,
    input wire logic globalReset,
    // Register window
    input wire logic [4:2] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [31:0] ioRdData,
    input wire logic ioRdValid,
    // Events and control
    input wire logic runControlBit,
    input wire logic processErrorEvt,
    input wire logic systemErrorEvt,
    input wire logic clearRunReq,
    // Frame and interrupt
    input wire logic [ufsu_pkg::FRAME_NUM_WIDTH-1:0] sofFrameNumber,
    input wire logic [31:0] frameListAddr,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic anyRst = hcReset || globalReset;
    wire logic cntWr = ioWrite && ioAddr == 3'h1 && !runControlBit;
    sequence fatal_s;
        (processErrorEvt || systemErrorEvt) && !anyRst;
    endsequence
    sequence quiet_s;
        !ioWrite && !anyRst;
    endsequence
    rd_answer_a: assert property (ioRead |=> ioRdValid)
        else $error("read not answered");
    rd_pulse_a: assert property (ioRdValid |-> $past(ioRead))
        else $error("read answer without request");
    rd_idle_a: assert property (!ioRdValid |-> ioRdData == 32'h0)
        else $error("read data not zero when idle");
    fatal_stop_a: assert property (fatal_s |=> clearRunReq)
        else $error("run clear missing after fatal error");
    stop_cause_a: assert property (clearRunReq |-> $past(processErrorEvt || systemErrorEvt))
        else $error("run clear without cause");
    fatal_irq_a: assert property (fatal_s ##1 quiet_s |=> irq)
        else $error("fatal error did not interrupt");
    list_index_a: assert property (frameListAddr[11:0] == {sofFrameNumber[9:0], 2'b00})
        else $error("frame list address mismatch");
    frame_step_a: assert property ($changed(sofFrameNumber) |->
        sofFrameNumber == $past(sofFrameNumber) + 1'b1 || $past(cntWr || anyRst, 2) || anyRst)
        else $error("frame number jumped");
endmodule
bind ufsu_core ufsu_core_props ufsu_core_props_inst (.sys_clk, .resetn, .hcReset, .globalReset,
    .ioAddr, .ioWrite, .ioRead, .ioRdData, .ioRdValid, .runControlBit, .processErrorEvt,
    .systemErrorEvt, .clearRunReq, .sofFrameNumber, .frameListAddr, .irq);

// ===== dv/ufsu_core_bench.sv
// Purpose: Self-checking bench of the frame and status core
// Assumes: Counter strobe every cycle, so a frame is trim plus 11936 cycles
// Notes: Reads are checked from a queue of expected values
`timescale 1ns/1ps
module ufsu_core_bench;
    logic sys_clk = 1'b0, resetn = 1'b0, hcReset = 1'b0, globalReset = 1'b0;
    logic [4:2] ioAddr = 3'h0;
    logic [3:0] ioByteEn = 4'h0;
    logic ioWrite = 1'b0, ioRead = 1'b0, ioRdValid, irq, clearRunReq, runControlBit;
    logic [31:0] ioWrData = 32'h0, ioRdData, frameListAddr, base;
    logic [31:0] seed = 32'h4D3D5AF4;
    logic globalSuspend = 1'b0, transactionBusy = 1'b0, setRun = 1'b0, clrRun = 1'b0;
    logic processErrorEvt, systemErrorEvt, resumeSignal, xferDone, xferError;
    logic interruptOnComplete, shortPacketDetect, sofTick, sofStrobe;
    logic [6:0] evv = 7'h0;
    logic [10:0] actualLength = 11'h0, maxLength = 11'h011, sofFrameNumber, cnt;
    logic [6:0] evTab [7] = '{7'h0A, 7'h0C, 7'h0E, 7'h09, 7'h09, 7'h10, 7'h10};
    logic [5:0] stTab [7] = '{6'h01, 6'h02, 6'h03, 6'h01, 6'h00, 6'h00, 6'h04};
    logic [31:0] expQ [$];
    int bad_count = 0, cmp_count = 0, cyc = 0, t0, t1, t2;
    assign {processErrorEvt, systemErrorEvt, resumeSignal, xferDone} = evv[6:3];
    assign {xferError, interruptOnComplete, shortPacketDetect} = evv[2:0];
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    ufsu_core ufsu_core_inst (.sys_clk, .resetn, .hcReset, .globalReset, .ioAddr, .ioByteEn,
        .ioWrite, .ioRead, .ioWrData, .ioRdData, .ioRdValid, .runControlBit, .globalSuspend,
        .clearRunReq, .transactionBusy, .processErrorEvt, .systemErrorEvt, .resumeSignal,
        .xferDone, .xferError, .interruptOnComplete, .shortPacketDetect, .actualLength,
        .maxLength, .sofTick, .sofStrobe, .sofFrameNumber, .frameListAddr, .irq);
    ufsu_cmd_model ufsu_cmd_model_inst (.sys_clk, .resetn, .setRun, .clrRun, .clearRunReq,
        .runControlBit, .sofTick);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [3:0] be, input logic [31:0] d);
        ioAddr = a;
        ioByteEn = be;
        ioWrData = d;
        ioWrite = 1'b1;
        step(1);
        ioWrite = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [2:0] a, input logic [31:0] e);
        expQ.push_back(e);
        ioAddr = a;
        ioByteEn = 4'hF;
        ioRead = 1'b1;
        step(1);
        ioRead = 1'b0;
        step(1);
    endtask
    task automatic ev(input logic [6:0] v);
        evv = v;
        step(1);
        evv = 7'h0;
        step(2);
    endtask
    task automatic waitSof(output int t);
        int k;
        k = 0;
        do begin
            step(1);
            k++;
        end while (sofStrobe !== 1'b1 && k < 13000);
        if (k >= 13000) begin
            bad_count++;
            summarize();
        end
        t = cyc;
    endtask

    always @(negedge sys_clk) begin
        if (ioRdValid === 1'b1) begin
            chk(ioRdData, expQ.pop_front());
        end
    end

    initial begin
        step(2);
        resetn = 1'b1;
        rd(3'h0, 32'h0);
        rd(3'h1, 32'h0);
        rd(3'h3, 32'h40);
        rd(3'h4, 32'h0);
        seed = lfsr(seed);
        base = seed;
        seed = lfsr(seed);
        cnt = seed[10:0];
        wr(3'h1, 4'h1, 32'hF);
        wr(3'h2, 4'hF, base);
        rd(3'h2, base & 32'hFFFFF000);
        wr(3'h1, 4'hC, {5'h0, cnt, 16'h0});
        wr(3'h1, 4'h4, {5'h0, ~cnt, 16'h0});
        rd(3'h1, {5'h0, cnt, 12'h0, 4'hF});
        chk(frameListAddr, {base[31:12], cnt[9:0], 2'b00});
        wr(3'h1, 4'h1, 32'h0);
        for (int i = 0; i < 7; i++) begin
            globalSuspend = (i == 6);
            actualLength = (i == 3) ? 11'h010 : 11'h011;
            ev(evTab[i]);
            rd(3'h0, {10'h0, stTab[i], 16'h0});
            chk({31'h0, irq}, 32'h0);
            wr(3'h0, 4'h4, 32'h003F0000);
        end
        globalSuspend = 1'b0;
        wr(3'h1, 4'h1, 32'h4);
        ev(7'h0A);
        chk({31'h0, irq}, 32'h1);
        wr(3'h0, 4'h4, 32'h00020000);
        chk({31'h0, irq}, 32'h1);
        wr(3'h0, 4'h4, 32'h00010000);
        step(1);
        chk({31'h0, irq}, 32'h0);
        wr(3'h1, 4'h1, 32'h0);
        setRun = 1'b1; // base is loaded before run
        step(1);
        setRun = 1'b0;
        waitSof(t0);
        wr(3'h3, 4'h1, 32'h0);
        wr(3'h1, 4'hC, 32'h07FF0000);
        rd(3'h1, {5'h0, cnt, 16'h0});
        waitSof(t1);
        chk(t1 - t0, 32'h2EE0);
        rd(3'h1, {5'h0, cnt + 11'h1, 16'h0});
        chk({21'h0, sofFrameNumber}, {21'h0, cnt + 11'h1});
        waitSof(t2);
        chk(t2 - t1, 32'h2EA0);
        transactionBusy = 1'b1;
        clrRun = 1'b1;
        step(1);
        clrRun = 1'b0;
        step(3);
        rd(3'h0, 32'h0);
        transactionBusy = 1'b0;
        step(2);
        rd(3'h0, 32'h00200000);
        wr(3'h0, 4'h4, 32'h003F0000);
        setRun = 1'b1;
        step(1);
        setRun = 1'b0;
        step(2);
        ev(7'h40);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, runControlBit}, 32'h0);
        rd(3'h0, 32'h00300000);
        wr(3'h0, 4'h4, 32'h003F0000);
        step(1);
        chk({31'h0, irq}, 32'h0);
        ev(7'h20);
        rd(3'h0, 32'h00080000);
        wr(3'h3, 4'h1, 32'hFF);
        rd(3'h3, 32'h7F);
        hcReset = 1'b1;
        step(1);
        hcReset = 1'b0;
        rd(3'h3, 32'h40);
        rd(3'h0, 32'h0);
        wr(3'h3, 4'h1, 32'h11);
        globalReset = 1'b1;
        step(1);
        globalReset = 1'b0;
        rd(3'h3, 32'h40);
        step(2);
        chk(expQ.size(), 32'h0);
        summarize();
    end
endmodule
